//--- logic/cicr_regs.sv
// Identity, operating conditions and device specific data registers.
// Assumes decoded commands on sys_clk_in and a host link clock pin.

`default_nettype none

module cicr_regs #(
  parameter logic [7:0] MAKER_CODE = 8'h5a,    // arbitrary value
  parameter logic [1:0] PACKAGE_KIND = 2'h1,
  parameter logic [7:0] OEM_CODE = 8'h3c,      // arbitrary value
  parameter logic [47:0] PRODUCT_NAME = 48'h4e4f4e414d45, // arbitrary
  parameter logic [7:0] PRODUCT_REV = 8'h01,   // arbitrary value
  parameter logic [31:0] SERIAL_NUMBER = 32'h00000001,
  parameter logic [7:0] BUILD_DATE = 8'h00,
  parameter logic [1:0] ACCESS_MODE = cicr_pkg::MODE_SECTOR,
  parameter logic [15:0] PWRUP_CYCLES = cicr_pkg::PWRUP_DEFAULT
) (
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic factory_clear_in,
  input wire logic link_clk_in,
  input wire cicr_pkg::cicr_cmd_type cmd_in,
  output logic [127:0] identity_out,
  output logic [31:0] op_cond_out,
  output logic [127:0] dev_data_out,
  output logic resp_bit_out,
  output logic resp_oe_out,
  output logic busy_out,
  output logic prog_done_out,
  output logic prog_refused_out
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (PWRUP_CYCLES == 16'h0000) begin : g_bad_pwrup
    $error("PWRUP_CYCLES must be at least one");
  end
  if (ACCESS_MODE != cicr_pkg::MODE_BYTE &&
      ACCESS_MODE != cicr_pkg::MODE_SECTOR) begin : g_bad_mode
    $error("ACCESS_MODE must be byte or sector");
  end

  typedef struct packed {
    cicr_pkg::cicr_phase_type phase;
    logic [127:0] sh;
    logic [7:0] cnt;
    logic lk_s1;
    logic lk_s2;
    logic lk_s3;
    logic [15:0] pwr_cnt;
    logic pwr_done;
    logic [127:0] id;
    logic [31:0] operating_conditions;
    logic [127:0] device_specific_data;
    logic resp_bit;
    logic resp_oe;
    logic busy;
    logic prog_req;
    cicr_pkg::cicr_nv_bits_type prog_bits;
    logic done;
    logic refused;
  } cicr_regs_state_type;

  cicr_regs_state_type r, n;
  logic [7:0] nv_bits;
  logic nv_ok;
  logic nv_refused;
  logic [119:0] id_cover;
  logic [127:0] id_image;
  logic [119:0] csd_cover;
  logic [127:0] csd_image;
  logic [31:0] ocr_image;
  logic link_rise;

  // ----------------------------------------------------------------
  // Programmable cells
  // ----------------------------------------------------------------
  cicr_nv_cells u_nv (
    .sys_clk_in(sys_clk_in),
    .factory_clear_in(factory_clear_in),
    .prog_req_in(r.prog_req),
    .prog_bits_in(r.prog_bits),
    .nv_bits_out(nv_bits),
    .prog_ok_out(nv_ok),
    .prog_refused_out(nv_refused)
  );

  // ----------------------------------------------------------------
  // Register images
  // ----------------------------------------------------------------
  // Identity fields with the check appended
  assign id_cover = {MAKER_CODE, 6'h00, PACKAGE_KIND, OEM_CODE,
                     PRODUCT_NAME, PRODUCT_REV, SERIAL_NUMBER,
                     BUILD_DATE};
  assign id_image = {id_cover, cicr_pkg::check7(id_cover),
                     1'b1};

  // Device specific data: fixed part, cells, check
  assign csd_cover = {cicr_pkg::CSD_FIXED, nv_bits};
  assign csd_image = {csd_cover, cicr_pkg::check7(csd_cover),
                      1'b1};

  // Operating conditions with busy bit from the power-up timer
  assign ocr_image = {r.pwr_done, ACCESS_MODE, cicr_pkg::OCR_RSVD_HI,
                      cicr_pkg::OCR_VOLT_WINDOW};

  // Rising edge of the sampled link clock
  assign link_rise = r.lk_s2 & ~r.lk_s3;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [127:0] load;
    logic [7:0] len;
    logic start;
    load = 128'h0;
    len = cicr_pkg::LEN_WIDE;
    start = 1'b0;
    n = r;
    n.lk_s1 = link_clk_in;
    n.lk_s2 = r.lk_s1;
    n.lk_s3 = r.lk_s2;
    n.id = id_image;
    n.device_specific_data = csd_image;
    n.operating_conditions = ocr_image;
    n.prog_req = 1'b0;
    n.done = nv_ok;
    n.refused = nv_refused;
    // Internal power-up routine
    if (!r.pwr_done) begin
      if (r.pwr_cnt == PWRUP_CYCLES - 16'h0001) begin
        n.pwr_done = 1'b1;
      end else begin
        n.pwr_cnt = r.pwr_cnt + 16'h0001;
      end
    end
    unique case (r.phase)
      cicr_pkg::PH_IDLE: begin
        if (cmd_in.valid) begin
          if (cmd_in.index == cicr_pkg::CMD_SEND_ID) begin
            load = r.id;
            start = 1'b1;
          end else if (cmd_in.index == cicr_pkg::CMD_SEND_DATA) begin
            load = r.device_specific_data;
            start = 1'b1;
          end else if (cmd_in.index == cicr_pkg::CMD_OP_COND) begin
            load = {r.operating_conditions, 96'h0};
            len = cicr_pkg::LEN_SHORT;
            start = 1'b1;
          end else if (cmd_in.index == cicr_pkg::CMD_PROGRAM) begin
            // Read-only part must match, cells go to the store
            if (cmd_in.data[127:16] == cicr_pkg::CSD_FIXED) begin
              n.prog_req = 1'b1;
              n.prog_bits = cmd_in.data[15:8];
            end else begin
              n.refused = 1'b1;
            end
          end
        end
        if (start) begin
          n.sh = load;
          n.cnt = len;
          n.resp_bit = load[127];
          n.resp_oe = 1'b1;
          n.busy = 1'b1;
          n.phase = cicr_pkg::PH_SEND;
        end
      end
      cicr_pkg::PH_SEND: begin
        // One bit per link clock rise, most significant first
        if (link_rise) begin
          if (r.cnt == 8'h01) begin
            n.resp_bit = 1'b0;
            n.resp_oe = 1'b0;
            n.busy = 1'b0;
            n.phase = cicr_pkg::PH_IDLE;
          end else begin
            n.sh = {r.sh[126:0], 1'b0};
            n.resp_bit = r.sh[126];
            n.cnt = r.cnt - 8'h01;
          end
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign identity_out = r.id;
  assign op_cond_out = r.operating_conditions;
  assign dev_data_out = r.device_specific_data;
  assign resp_bit_out = r.resp_bit;
  assign resp_oe_out = r.resp_oe;
  assign busy_out = r.busy;
  assign prog_done_out = r.done;
  assign prog_refused_out = r.refused;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Cycles since reset, saturating, for the power-up check
  logic [15:0] since_rst;
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      since_rst <= 16'h0000;
    end else if (since_rst != 16'hffff) begin
      since_rst <= since_rst + 16'h0001;
    end
  end

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (srst_in);

  a_serial_field: assert property (
    !$past(srst_in) |-> identity_out[cicr_pkg::SERIAL_MSB:
      cicr_pkg::SERIAL_LSB] == SERIAL_NUMBER)
    else $error("serial number field wrong");

  a_maker_field: assert property (
    !$past(srst_in) |-> identity_out[127:cicr_pkg::MAKER_LSB]
      == MAKER_CODE && identity_out[15:8] == BUILD_DATE)
    else $error("identity field placement wrong");

  a_check_fields: assert property (
    !$past(srst_in) |-> identity_out[0] && dev_data_out[0] &&
      identity_out[7:1] == cicr_pkg::check7(identity_out[127:8]) &&
      dev_data_out[7:1] == cicr_pkg::check7(dev_data_out[127:8]))
    else $error("check field or constant bit wrong");

  a_busy_timing: assert property (
    op_cond_out[cicr_pkg::BUSY_BIT] |-> since_rst > PWRUP_CYCLES)
    else $error("power-up status set too early");

  a_voltage_window: assert property (
    !$past(srst_in) |-> op_cond_out[30:0] == {ACCESS_MODE,
      cicr_pkg::OCR_RSVD_HI, cicr_pkg::OCR_VOLT_WINDOW})
    else $error("operating conditions layout wrong");

  a_fixed_data: assert property (
    !$past(srst_in) |-> dev_data_out[127:cicr_pkg::FIXED_LSB]
      == cicr_pkg::CSD_FIXED)
    else $error("read-only data bits wrong");

  a_prog_refuse: assert property (
    r.phase == cicr_pkg::PH_IDLE && cmd_in.valid &&
    cmd_in.index == cicr_pkg::CMD_PROGRAM &&
    cmd_in.data[127:16] != cicr_pkg::CSD_FIXED
    |=> prog_refused_out ##1 !prog_done_out)
    else $error("program touching read-only bits not refused");

  a_id_response: assert property (
    r.phase == cicr_pkg::PH_IDLE && cmd_in.valid &&
    cmd_in.index == cicr_pkg::CMD_SEND_ID
    |=> resp_oe_out && busy_out && r.cnt == cicr_pkg::LEN_WIDE &&
      resp_bit_out == identity_out[127])
    else $error("identity response did not start");

  // Short reply starts with the power-up status bit
  a_ocr_reply: assert property (
    r.phase == cicr_pkg::PH_IDLE && cmd_in.valid &&
    cmd_in.index == cicr_pkg::CMD_OP_COND
    |=> r.cnt == cicr_pkg::LEN_SHORT &&
      resp_bit_out == $past(op_cond_out[cicr_pkg::BUSY_BIT]))
    else $error("operating conditions reply did not start");

  // Reply ends after the last counted link edge
  a_reply_ends: assert property (
    r.phase == cicr_pkg::PH_SEND && link_rise && r.cnt == 8'h01
    |=> !resp_oe_out && !busy_out && !resp_bit_out)
    else $error("reply did not end after its last bit");

  // A program met while busy never reaches the cells
  a_busy_ignores: assert property (
    busy_out && cmd_in.valid && cmd_in.index == cicr_pkg::CMD_PROGRAM
    |-> ##3 !prog_done_out)
    else $error("program taken during a reply");

  // Cells reach the image one cycle after they change
  a_cells_on_bus: assert property (
    !$past(srst_in) |-> dev_data_out[15:8] == $past(nv_bits))
    else $error("programmable cells not mirrored");

  // Power-up status stays set once reached
  a_ready_holds: assert property (
    op_cond_out[cicr_pkg::BUSY_BIT] |=> op_cond_out[cicr_pkg::BUSY_BIT])
    else $error("power-up status dropped");

  c_send_id: cover property (r.phase == cicr_pkg::PH_IDLE &&
    cmd_in.valid && cmd_in.index == cicr_pkg::CMD_SEND_ID);
  c_op_cond_ready: cover property (op_cond_out[31] && resp_oe_out);
  c_prog_done: cover property (prog_done_out);
  c_prog_refused: cover property (prog_refused_out);
  c_reply_end: cover property ($fell(resp_oe_out));

endmodule : cicr_regs

`default_nettype wire

//--- logic/cicr_pkg.sv
// Constants, carriers and the check function for the identity and
// configuration register bank of a managed flash device.
// Assumes a single 100 MHz system clock and a host-clocked command link.
//
// Notes on behaviour
// - A 128-bit identity register is readable during identification.
// - Identity bits 47:16 carry a unique per-part 32-bit serial number.
// - ID: maker 127:120, OEM 111:104, name 103:56, rev 55:48, date 15:8.
// - Both 128-bit registers hold a seven-bit check in 7:1; bit 0 reads one.
// - 32-bit operating conditions: voltage profile plus power-up status bit.
// - Operating conditions bit 31 reads low until power-up has finished.
// - Bits 30:29 give addressing: 00b byte, 10b sector; host follows it.
// - Voltage bits 23:15 ones, 14:8 zero, 7 one; 28:24 and 6:0 zero.
// - Only programmable data bits change, only by the program command 27.
// - Data register layout version 3h at 127:126, revision 4h at 125:122.
// - Async access code 7Fh at 119:112, clocked access 8h at 111:104.
// - Bus rate code 32h at 103:96, command class mask 5F5h at 95:84.
// - Read block code 83:80 and write block code 25:22 both read 9h.
// - Bits 79, 78, 77, 76 and 21 all read zero.
// - Capacity FFFh at 73:62, scale 7h at 49:47, current codes 6h each.
// - Erase unit size 46:42 and erase unit scale 41:37 both read 1Fh.
// - Protect size Fh at 36:32, bit 31 one, write speed 5h at 28:26.
// - Bits 15,14,13,11:10 program once; 12,9:8 rewritable; all ship as zero.
// - Once-cells program once; rewritable ones outlast power loss and resets.

`default_nettype none

package cicr_pkg;

  // ----------------------------------------------------------------
  // Command indices handled by the bank
  // ----------------------------------------------------------------
  localparam logic [5:0] CMD_OP_COND = 6'h01;
  localparam logic [5:0] CMD_SEND_ID = 6'h02;
  localparam logic [5:0] CMD_SEND_DATA = 6'h09;
  localparam logic [5:0] CMD_PROGRAM = 6'h1b;

  // ----------------------------------------------------------------
  // Field positions and lengths
  // ----------------------------------------------------------------
  localparam int CHECK_LSB = 1;
  localparam int CHECK_MSB = 7;
  localparam int COVER_LSB = 8;
  localparam int FIXED_LSB = 16;
  localparam int SERIAL_LSB = 16;
  localparam int SERIAL_MSB = 47;
  localparam int MAKER_LSB = 120;
  localparam int BUSY_BIT = 31;
  localparam logic [7:0] LEN_WIDE = 8'h80;
  localparam logic [7:0] LEN_SHORT = 8'h20;
  localparam logic [6:0] CHECK_POLY = 7'h09;
  localparam logic [15:0] PWRUP_DEFAULT = 16'h03e8;

  // ----------------------------------------------------------------
  // Operating conditions layout
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_BYTE = 2'h0;
  localparam logic [1:0] MODE_SECTOR = 2'h2;
  localparam logic [4:0] OCR_RSVD_HI = 5'h00;
  localparam logic [23:0] OCR_VOLT_WINDOW = 24'hff8080;

  // ----------------------------------------------------------------
  // Read-only device specific data, bits 127:16
  // ----------------------------------------------------------------
  localparam logic [111:0] CSD_FIXED = {
    2'h3, 4'h4, 2'h0, 8'h7f, 8'h08, 8'h32, 12'h5f5, 4'h9,
    1'h0, 1'h0, 1'h0, 1'h0, 2'h0, 12'hfff,
    3'h6, 3'h6, 3'h6, 3'h6, 3'h7, 5'h1f, 5'h1f, 5'h0f,
    1'h1, 2'h0, 3'h5, 4'h9, 1'h0, 4'h0, 1'h0};

  // Programmable cells, packed in the order of bits 15:8
  typedef struct packed {
    logic content_layout_group;
    logic copy_flag;
    logic lasting_lock_flag;
    logic temporary_lock_flag;
    logic [1:0] content_format;
    logic [1:0] ecc_code;
  } cicr_nv_bits_type;

  // Decoded command from the command layer
  typedef struct packed {
    logic valid;
    logic [5:0] index;
    logic [127:0] data;
  } cicr_cmd_type;

  typedef enum logic [0:0] {
    PH_IDLE = 1'b0,
    PH_SEND = 1'b1
  } cicr_phase_type;

  // Seven-bit check over bits 127:8, most significant first
  function automatic logic [6:0] check7(input logic [119:0] d);
    logic [6:0] c;
    logic fb;
    c = 7'h00;
    for (int i = 119; i >= 0; i--) begin
      fb = d[i] ^ c[6];
      c = {c[5:0], 1'b0};
      if (fb) begin
        c = c ^ CHECK_POLY;
      end
    end
    return c;
  endfunction : check7

endpackage : cicr_pkg

`default_nettype wire

//--- logic/cicr_nv_cells.sv
// Programmable cells of the device specific data register.
// Assumes factory_clear_in is used only at manufacture; resets leave it.

`default_nettype none

module cicr_nv_cells (
  input wire logic sys_clk_in,
  input wire logic factory_clear_in,
  input wire logic prog_req_in,
  input wire cicr_pkg::cicr_nv_bits_type prog_bits_in,
  output logic [7:0] nv_bits_out,
  output logic prog_ok_out,
  output logic prog_refused_out
);

  typedef struct packed {
    cicr_pkg::cicr_nv_bits_type cells;
    logic [3:0] used;
    logic ok;
    logic refused;
  } cicr_nv_state_type;

  cicr_nv_state_type r, n;

  // ----------------------------------------------------------------
  // Once-only fields: group flag, copy, lasting lock, format
  // ----------------------------------------------------------------
  // Next state of the cells
  always_comb begin
    logic [3:0] chg;
    chg = 4'h0;
    n = r;
    n.ok = 1'b0;
    n.refused = 1'b0;
    chg[3] = prog_bits_in.content_layout_group ^
             r.cells.content_layout_group;
    chg[2] = prog_bits_in.copy_flag ^ r.cells.copy_flag;
    chg[1] = prog_bits_in.lasting_lock_flag ^ r.cells.lasting_lock_flag;
    chg[0] = |(prog_bits_in.content_format ^ r.cells.content_format);
    if (prog_req_in) begin
      if (|(chg & r.used)) begin
        n.refused = 1'b1;
      end else begin
        n.cells = prog_bits_in;
        n.used = r.used | chg;
        n.ok = 1'b1;
      end
    end
  end

  // Cells keep their value through every reset but the factory clear
  always_ff @(posedge sys_clk_in) begin
    if (factory_clear_in) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign nv_bits_out = r.cells;
  assign prog_ok_out = r.ok;
  assign prog_refused_out = r.refused;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_lock_holds: assert property (@(posedge sys_clk_in)
    disable iff (factory_clear_in)
    r.cells.lasting_lock_flag |=> r.cells.lasting_lock_flag)
    else $error("lasting lock cell was cleared");

  a_used_refuses: assert property (@(posedge sys_clk_in)
    disable iff (factory_clear_in)
    prog_req_in && r.used[2] && (prog_bits_in.copy_flag
      != r.cells.copy_flag) |=> prog_refused_out && !prog_ok_out)
    else $error("second programming of a once cell taken");

endmodule : cicr_nv_cells

`default_nettype wire

//--- verification/cicr_host_model.sv
// Behavioural host that clocks the response link and shifts in reply bits.
// Assumes the device raises resp_oe while it answers, most significant first.

`default_nettype none

module cicr_host_model (
  input wire logic resp_oe_in,
  input wire logic resp_bit_in,
  input wire logic slow_in,
  output logic link_clk_out,
  output logic [127:0] capture_out,
  output logic [7:0] count_out
);
  timeunit 1ns;
  timeprecision 1ns;

  // Link clock runs only inside a frame and stays low between frames
  initial begin
    link_clk_out = 1'b0;
    capture_out = '0;
    count_out = 8'h00;
    forever begin
      wait (resp_oe_in === 1'b1);
      count_out = 8'h00;
      #3;
      while (resp_oe_in === 1'b1) begin
        #(slow_in ? 120 : 40);
        link_clk_out = 1'b1;
        capture_out = {capture_out[126:0], resp_bit_in};
        count_out = count_out + 8'h01;
        #40;
        link_clk_out = 1'b0;
      end
    end
  end

endmodule : cicr_host_model

`default_nettype wire

//--- verification/tb_top.sv
// Self-checking bench for the identity and configuration register bank.
// Assumes cicr_regs as top with the behavioural host model on its link.

`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------------------------------
  // Expected images and signals
  // ----------------------------------------------------------------
  localparam logic [111:0] FIX = {2'h3, 4'h4, 2'h0, 8'h7f, 8'h08, 8'h32,
    12'h5f5, 4'h9, 4'h0, 2'h0, 12'hfff, 12'hdb6, 3'h7, 5'h1f, 5'h1f,
    5'h0f, 1'h1, 2'h0, 3'h5, 4'h9, 1'h0, 4'h0, 1'h0};
  // Maker and name values are arbitrary; OEM and revision are defaults
  localparam logic [119:0] ID_HI = {8'h61, 6'h00, 2'h1, 8'h3c,
    48'h0a1b2c3d4e5f, 8'h01, 32'h1234abcd, 8'h3a};
  localparam logic [31:0] OCR_EXP = {1'b1, 2'h2, 5'h00, 9'h1ff, 7'h00,
    1'b1, 7'h00};

  typedef struct packed {
    logic [5:0] idx;
    logic [7:0] len;
    logic slow;
    logic [127:0] exp;
  } cicr_row_type;

  logic sys_clk_in, srst_in, factory_clear_in, link_clk, slow;
  logic resp_bit, resp_oe, busy, prog_done, prog_refused;
  logic [127:0] identity, dev_data, capture;
  logic [31:0] op_cond;
  logic [7:0] count;
  cicr_pkg::cicr_cmd_type cmd;
  cicr_row_type rows [3];
  int bad_count, cmp_count, cyc, done_cnt, ref_cnt;

  cicr_regs #(.MAKER_CODE(8'h61), .PRODUCT_NAME(48'h0a1b2c3d4e5f),
    .SERIAL_NUMBER(32'h1234abcd), .BUILD_DATE(8'h3a),
    .PWRUP_CYCLES(16'h000a)
  ) cicr_regs_i (
    .sys_clk_in(sys_clk_in), .srst_in(srst_in),
    .factory_clear_in(factory_clear_in), .link_clk_in(link_clk),
    .cmd_in(cmd), .identity_out(identity), .op_cond_out(op_cond),
    .dev_data_out(dev_data), .resp_bit_out(resp_bit),
    .resp_oe_out(resp_oe), .busy_out(busy), .prog_done_out(prog_done),
    .prog_refused_out(prog_refused));

  cicr_host_model cicr_host_model_i (.resp_oe_in(resp_oe),
    .resp_bit_in(resp_bit), .slow_in(slow), .link_clk_out(link_clk),
    .capture_out(capture), .count_out(count));

  // Clock source
  initial begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end

  // Pulse counters and hang guard
  always @(posedge sys_clk_in) begin
    cyc <= cyc + 1;
    if (prog_done === 1'b1) begin
      done_cnt <= done_cnt + 1;
    end
    if (prog_refused === 1'b1) begin
      ref_cnt <= ref_cnt + 1;
    end
    if (cyc == 20000) begin
      bad_count++;
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [127:0] seal(input logic [119:0] d);
    logic [6:0] c;
    c = 7'h00;
    for (int i = 119; i >= 0; i--) begin
      c = {c[5:0], 1'b0} ^ (((d[i] ^ c[6]) == 1'b1) ? 7'h09 : 7'h00);
    end
    return {d, c, 1'b1};
  endfunction : seal

  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  task automatic send(input logic [5:0] idx, input logic [127:0] d);
    @(posedge sys_clk_in);
    cmd <= '{1'b1, idx, d};
    @(posedge sys_clk_in);
    cmd.valid <= 1'b0;
  endtask : send

  task automatic wait_frame();
    int n;
    n = 0;
    while (resp_oe !== 1'b1 && n < 5) begin
      @(posedge sys_clk_in);
      n++;
    end
    while (resp_oe === 1'b1 && n < 4000) begin
      @(posedge sys_clk_in);
      n++;
    end
    if (n >= 4000) begin
      bad_count++;
    end
  endtask : wait_frame

  task automatic read_row(input cicr_row_type r);
    slow <= r.slow;
    send(r.idx, 128'h0);
    wait_frame();
    chk((r.len == 8'h20) ? {96'h0, capture[31:0]} : capture, r.exp);
    chk(count, r.len);
  endtask : read_row

  task automatic prog(input logic [111:0] f, input logic [7:0] c,
                      input int dn, input int rf);
    int d0, r0;
    d0 = done_cnt;
    r0 = ref_cnt;
    send(cicr_pkg::CMD_PROGRAM, {f, c, 8'h00});
    repeat (4) @(posedge sys_clk_in);
    #1;
    chk(done_cnt - d0, dn);
    chk(ref_cnt - r0, rf);
  endtask : prog

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    srst_in = 1'b1;
    factory_clear_in = 1'b1;
    cmd = '0;
    slow = 1'b0;
    repeat (3) @(posedge sys_clk_in);
    srst_in <= 1'b0;
    factory_clear_in <= 1'b0;
    #1;
    chk(identity, 128'h0);
    chk(op_cond, 32'h0);
    repeat (5) @(posedge sys_clk_in);
    #1;
    chk(identity, seal(ID_HI));
    chk(op_cond, OCR_EXP & 32'h7fffffff);
    chk(dev_data, seal({FIX, 8'h00}));
    repeat (10) @(posedge sys_clk_in);
    #1;
    chk(op_cond, OCR_EXP);
    // Read each register over the link, the last one with a slow host
    rows[0] = '{cicr_pkg::CMD_OP_COND, 8'h20, 1'b0, {96'h0, OCR_EXP}};
    rows[1] = '{cicr_pkg::CMD_SEND_ID, 8'h80, 1'b0, seal(ID_HI)};
    rows[2] = '{cicr_pkg::CMD_SEND_DATA, 8'h80, 1'b1, seal({FIX, 8'h00})};
    for (int i = 0; i < 3; i++) begin
      read_row(rows[i]);
    end
    // Rewritable cells change freely, once-only cells lock
    prog(FIX, 8'h13, 1, 0);
    chk(dev_data, seal({FIX, 8'h13}));
    prog(FIX, 8'h00, 1, 0);
    chk(dev_data, seal({FIX, 8'h00}));
    prog(FIX, 8'h20, 1, 0);
    prog(FIX, 8'h00, 0, 1);
    prog({FIX[111:1], ~FIX[0]}, 8'h20, 0, 1);
    chk(dev_data, seal({FIX, 8'h20}));
    // A program during a reply is ignored
    slow <= 1'b0;
    send(cicr_pkg::CMD_SEND_ID, 128'h0);
    #1;
    chk(busy, 1'b1);
    prog(FIX, 8'h24, 0, 0);
    wait_frame();
    chk(capture, seal(ID_HI));
    #1;
    chk(busy, 1'b0);
    // Cells survive a reset in mid-run
    @(posedge sys_clk_in);
    srst_in <= 1'b1;
    repeat (3) @(posedge sys_clk_in);
    srst_in <= 1'b0;
    repeat (15) @(posedge sys_clk_in);
    #1;
    chk(dev_data, seal({FIX, 8'h20}));
    chk(op_cond, OCR_EXP);
    read_row('{cicr_pkg::CMD_SEND_DATA, 8'h80, 1'b0,
      seal({FIX, 8'h20})});
    tally_and_finish();
  end

  initial begin
    bad_count = 0;
    cmp_count = 0;
    cyc = 0;
    done_cnt = 0;
    ref_cnt = 0;
  end

endmodule : tb_top

`default_nettype wire
